/* rtl/fr_alu_pkg.sv */
// Constants and types for the file-register ALU and branch datapath
package fr_alu_pkg;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned ADDR_W      = 5;
  localparam int unsigned REG_COUNT   = 32;
  localparam int unsigned PC_W        = 11;
  localparam int unsigned JUMP_W      = 9;
  localparam int unsigned PAGE_LO_BIT = 5;
  localparam int unsigned PAGE_HI_BIT = 6;
  localparam int unsigned ZERO_BIT    = 2;
  localparam logic [7:0]  STATUS_RST  = 8'h18;
  localparam logic [7:0]  ACC_RST     = 8'h00;
  localparam logic [7:0]  FILE_RST    = 8'h00;
  localparam logic [10:0] PC_RST      = 11'h000;
  localparam logic        DEST_ACC    = 1'b0;
  localparam logic        DEST_FILE   = 1'b1;

  typedef enum logic [2:0] {
    OP_NO_OPERATION,
    OP_COMPLEMENT_FILE,
    OP_DECREMENT_FILE,
    OP_INCREMENT_FILE,
    OP_DECREMENT_SKIP_IF_NULL,
    OP_INCREMENT_SKIP_IF_NULL,
    OP_JUMP_ABSOLUTE,
    OP_OR_LITERAL_INTO_ACC
  } op_t;
endpackage

/* rtl/fr_alu_unit.sv */
// Combinational result and zero detect for the file-register operations
`timescale 1ns/10ps
module fr_alu_unit
  import fr_alu_pkg::*;
(
  input  wire logic [2:0] op_i,
  input  wire logic [7:0] file_i,
  input  wire logic [7:0] acc_i,
  input  wire logic [7:0] lit_i,
  output logic      [7:0] result_o,
  output logic            zero_o
);
  wire [7:0] inv_w = ~file_i;
  wire [7:0] dec_w = file_i - 8'h01;
  wire [7:0] inc_w = file_i + 8'h01;
  wire [7:0] orl_w = acc_i | lit_i;

  always_comb begin
    case (op_t'(op_i))
      OP_COMPLEMENT_FILE:        result_o = inv_w;
      OP_DECREMENT_FILE,
      OP_DECREMENT_SKIP_IF_NULL: result_o = dec_w;
      OP_INCREMENT_FILE,
      OP_INCREMENT_SKIP_IF_NULL: result_o = inc_w;
      OP_OR_LITERAL_INTO_ACC:    result_o = orl_w;
      default:                   result_o = 8'h00;
    endcase
  end

  assign zero_o = (result_o == 8'h00);
endmodule // fr_alu_unit

/* rtl/fr_alu_core.sv */
// File-register ALU, skip and absolute jump execution datapath
// Operation
// - File operand 0..31, one destination bit
// - Destination 0 to accumulator, 1 to file
// - Complement file, route result, update zero
// - Decrement file, route result, update zero
// - Increment file, route result, update zero
// - Decrement, skip on zero, flags kept
// - Increment, skip on zero, flags kept
// - Jump loads low bits, page from status
// - Jump takes two cycles, flags kept
// - OR literal into accumulator, update zero
// - Zero flag is a status bit
`timescale 1ns/10ps
module fr_alu_core
  import fr_alu_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        instr_valid_i,
  input  wire logic [2:0]  op_i,
  input  wire logic [4:0]  file_addr_i,
  input  wire logic        dest_i,
  input  wire logic [8:0]  imm_i,
  input  wire logic        status_wr_i,
  input  wire logic [7:0]  status_wdata_i,
  output logic      [7:0]  acc_o,
  output logic      [7:0]  status_o,
  output logic      [10:0] program_counter_o,
  output logic             flush_o,
  output logic             busy_o,
  output logic      [7:0]  file_rd_data_o
);
  logic [7:0]  file_mem [REG_COUNT];
  logic [7:0]  acc_r;
  logic [7:0]  status_r;
  logic [10:0] program_counter_r;
  logic        flush_r;
  logic [7:0]  rd_data_r;
  logic [7:0]  result_w;
  logic        zero_w;

  // Accept only when not executing a flush cycle
  wire         take_w    = instr_valid_i & ~flush_r;
  wire         op_nop_w  = ~take_w;
  wire [2:0]   op_eff_w  = op_nop_w ? 3'(OP_NO_OPERATION) : op_i;
  wire [7:0]   file_w    = file_mem[file_addr_i];

  fr_alu_unit u_alu (
    .op_i     (op_eff_w),
    .file_i   (file_w),
    .acc_i    (acc_r),
    .lit_i    (imm_i[7:0]),
    .result_o (result_w),
    .zero_o   (zero_w)
  );

  wire is_zflag_w = (op_eff_w == 3'(OP_COMPLEMENT_FILE))
                  | (op_eff_w == 3'(OP_DECREMENT_FILE))
                  | (op_eff_w == 3'(OP_INCREMENT_FILE))
                  | (op_eff_w == 3'(OP_OR_LITERAL_INTO_ACC));
  wire is_skip_w  = (op_eff_w == 3'(OP_DECREMENT_SKIP_IF_NULL))
                  | (op_eff_w == 3'(OP_INCREMENT_SKIP_IF_NULL));
  wire is_file_w  = is_skip_w | (is_zflag_w
                  & (op_eff_w != 3'(OP_OR_LITERAL_INTO_ACC)));
  wire is_jump_w  = (op_eff_w == 3'(OP_JUMP_ABSOLUTE));
  wire is_orl_w   = (op_eff_w == 3'(OP_OR_LITERAL_INTO_ACC));

  wire wr_file_w  = is_file_w & (dest_i == DEST_FILE);
  wire wr_acc_w   = is_orl_w | (is_file_w & (dest_i == DEST_ACC));
  wire skip_w     = is_skip_w & zero_w;
  wire flush_nxt  = skip_w | is_jump_w;

  wire [10:0] jump_pc_w = {status_r[PAGE_HI_BIT:PAGE_LO_BIT],
                           imm_i[JUMP_W-1:0]};
  wire [10:0] pc_nxt    = is_jump_w ? jump_pc_w
                        : (take_w | flush_r) ? program_counter_r + 11'h001
                        : program_counter_r;

  logic [7:0] status_nxt;
  always_comb begin
    status_nxt = status_wr_i ? status_wdata_i : status_r;
    if (is_zflag_w) begin
      status_nxt[ZERO_BIT] = zero_w;
    end
  end

  wire [7:0] acc_nxt     = wr_acc_w ? result_w : acc_r;
  wire [7:0] rd_data_nxt = wr_file_w ? result_w : file_w;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      acc_r <= ACC_RST;
    end else begin
      acc_r <= acc_nxt;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      status_r <= STATUS_RST;
    end else begin
      status_r <= status_nxt;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      program_counter_r <= PC_RST;
    end else begin
      program_counter_r <= pc_nxt;
    end
  end

  // Marks the cycle whose fetched instruction is dropped
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      flush_r <= 1'b0;
    end else begin
      flush_r <= flush_nxt;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rd_data_r <= FILE_RST;
    end else begin
      rd_data_r <= rd_data_nxt;
    end
  end

  generate
    for (genvar i = 0; i < REG_COUNT; i++) begin : g_file
      always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          file_mem[i] <= FILE_RST;
        end else if (wr_file_w && file_addr_i == 5'(i)) begin
          file_mem[i] <= result_w;
        end
      end
    end
  endgenerate

  assign acc_o             = acc_r;
  assign status_o          = status_r;
  assign program_counter_o = program_counter_r;
  assign flush_o           = flush_r;
  assign busy_o            = flush_r;
  assign file_rd_data_o    = rd_data_r;

  // Checks
  AST_ACC_ROUTE: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    (take_w && is_file_w && dest_i == DEST_ACC) |=> acc_r == $past(result_w))
    else $error("accumulator not written for destination 0");
  AST_FILE_ROUTE: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    (take_w && is_file_w && dest_i == DEST_FILE)
    |=> file_rd_data_o == $past(result_w))
    else $error("file register not written for destination 1");
  AST_FILE_KEEPS_ACC: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    (take_w && is_file_w && dest_i == DEST_FILE) |=> $stable(acc_r))
    else $error("accumulator changed for destination 1");
  AST_ACC_KEEPS_FILE: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    (take_w && is_file_w && dest_i == DEST_ACC)
    |=> file_rd_data_o == $past(file_w))
    else $error("file register changed for destination 0");

  AST_COMPLEMENT: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    (take_w && op_i == 3'(OP_COMPLEMENT_FILE) && dest_i == DEST_ACC)
    |=> acc_r == ~$past(file_w))
    else $error("complement result wrong");
  AST_COMPLEMENT_FILE: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    (take_w && op_i == 3'(OP_COMPLEMENT_FILE) && dest_i == DEST_FILE)
    |=> file_rd_data_o == ~$past(file_w))
    else $error("complement to file wrong");
  AST_DECREMENT: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    (take_w && op_i == 3'(OP_DECREMENT_FILE) && dest_i == DEST_ACC)
    |=> acc_r == $past(file_w) - 8'h01)
    else $error("decrement result wrong");
  AST_DECREMENT_FILE: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    (take_w && op_i == 3'(OP_DECREMENT_FILE) && dest_i == DEST_FILE)
    |=> file_rd_data_o == $past(file_w) - 8'h01)
    else $error("decrement to file wrong");
  AST_INCREMENT: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    (take_w && op_i == 3'(OP_INCREMENT_FILE) && dest_i == DEST_FILE)
    |=> file_rd_data_o == $past(file_w) + 8'h01)
    else $error("increment result wrong");
  AST_INCREMENT_ACC: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    (take_w && op_i == 3'(OP_INCREMENT_FILE) && dest_i == DEST_ACC)
    |=> acc_r == $past(file_w) + 8'h01)
    else $error("increment to accumulator wrong");

  AST_SKIP_DEC: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    (take_w && op_i == 3'(OP_DECREMENT_SKIP_IF_NULL) && dest_i == DEST_ACC)
    |=> acc_r == $past(file_w) - 8'h01)
    else $error("decrement and skip result wrong");
  AST_SKIP_INC: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    (take_w && op_i == 3'(OP_INCREMENT_SKIP_IF_NULL) && dest_i == DEST_FILE)
    |=> file_rd_data_o == $past(file_w) + 8'h01)
    else $error("increment and skip result wrong");
  AST_SKIP_FLUSH: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    (take_w && is_skip_w && zero_w) |=> flush_o ##1 !flush_o)
    else $error("zero result skip not one flush cycle");
  AST_SKIP_NO_FLUSH: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    (take_w && is_skip_w && !zero_w) |=> !flush_o)
    else $error("nonzero result skip flushed");
  AST_SKIP_FLAGS: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    (take_w && is_skip_w && !status_wr_i) |=> $stable(status_r))
    else $error("skip altered status");

  AST_JUMP_PC: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    (take_w && op_i == 3'(OP_JUMP_ABSOLUTE)) |=>
    program_counter_o == {$past(status_r[6:5]), $past(imm_i)})
    else $error("jump target wrong");
  AST_JUMP_TWO: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    (take_w && op_i == 3'(OP_JUMP_ABSOLUTE) && !status_wr_i)
    |=> flush_o && $stable(status_r) ##1 !flush_o)
    else $error("jump not two cycles or flags altered");
  AST_FLUSH_DROPS: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    (flush_r && instr_valid_i && !status_wr_i) |=> $stable(acc_r)
    && $stable(status_r)
    && program_counter_o == $past(program_counter_r) + 11'h001)
    else $error("instruction in flush cycle not dropped");

  AST_OR_ZERO: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    (take_w && op_i == 3'(OP_OR_LITERAL_INTO_ACC)) |=>
    acc_r == ($past(acc_r) | $past(imm_i[7:0]))
    && status_r[ZERO_BIT] == (acc_r == 8'h00))
    else $error("or literal or zero flag wrong");
  AST_ZERO_FLAG: assert property (@(posedge clk_i)
    disable iff (sys_rst_i)
    (take_w && is_zflag_w)
    |=> status_r[ZERO_BIT] == ($past(result_w) == 8'h00))
    else $error("zero flag does not follow result");

  COV_SKIP: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    take_w && is_skip_w && zero_w);
  COV_JUMP: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    take_w && is_jump_w);
  COV_ZERO: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    take_w && is_zflag_w && zero_w);
  COV_FILE_WR: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    wr_file_w);
  COV_FLUSH_DROP: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    flush_r && instr_valid_i);
endmodule // fr_alu_core

/* verification/file_register_alu_and_branch_tb.sv */
// Self-checking bench for the file-register ALU and branch datapath
`timescale 1ns/10ps
module file_register_alu_and_branch_tb import fr_alu_pkg::*;;
  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        instr_valid_i = 1'b0;
  logic [2:0]  op_i = 3'h0;
  logic [4:0]  file_addr_i = 5'h00;
  logic        dest_i = 1'b0;
  logic [8:0]  imm_i = 9'h000;
  logic        status_wr_i = 1'b0;
  logic [7:0]  status_wdata_i = 8'h00;
  logic [7:0]  acc_o, status_o, file_rd_data_o;
  logic [10:0] program_counter_o;
  logic        flush_o, busy_o;
  logic [7:0]  m_file [32] = '{default: FILE_RST};
  logic [7:0]  m_acc = ACC_RST;
  logic [7:0]  m_st = STATUS_RST;
  logic [7:0]  m_rd = 8'h00;
  logic [10:0] m_pc = PC_RST;
  logic        m_fl = 1'b0;
  int          error_cnt = 0;
  int          checks = 0;

  always #5 clk_i = ~clk_i;

  fr_alu_core fr_alu_core_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .instr_valid_i(instr_valid_i), .op_i(op_i), .file_addr_i(file_addr_i),
    .dest_i(dest_i), .imm_i(imm_i), .status_wr_i(status_wr_i),
    .status_wdata_i(status_wdata_i), .acc_o(acc_o), .status_o(status_o),
    .program_counter_o(program_counter_o), .flush_o(flush_o),
    .busy_o(busy_o), .file_rd_data_o(file_rd_data_o));

  task automatic chk(string nm, logic [10:0] exp, logic [10:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic chk_all();
    chk("acc", {3'h0, m_acc}, {3'h0, acc_o});
    chk("status", {3'h0, m_st}, {3'h0, status_o});
    chk("pc", m_pc, program_counter_o);
    chk("flush", {10'h000, m_fl}, {10'h000, flush_o});
    chk("busy", {10'h000, m_fl}, {10'h000, busy_o});
    chk("rd_data", {3'h0, m_rd}, {3'h0, file_rd_data_o});
  endtask

  // Hold keeps the instruction up into the flush cycle, where it is dropped
  task automatic exec(op_t op, logic [4:0] a, logic d, logic [8:0] k,
                      logic hold);
    logic [7:0] r;
    @(posedge clk_i);
    instr_valid_i <= 1'b1;
    op_i <= op;
    file_addr_i <= a;
    dest_i <= d;
    imm_i <= k;
    @(posedge clk_i);
    instr_valid_i <= hold;
    case (op)
      OP_COMPLEMENT_FILE: r = ~m_file[a];
      OP_DECREMENT_FILE, OP_DECREMENT_SKIP_IF_NULL: r = m_file[a] - 8'h01;
      OP_INCREMENT_FILE, OP_INCREMENT_SKIP_IF_NULL: r = m_file[a] + 8'h01;
      default: r = m_acc | k[7:0];
    endcase
    m_pc = m_pc + 11'h001;
    m_fl = (op inside {OP_DECREMENT_SKIP_IF_NULL, OP_INCREMENT_SKIP_IF_NULL}
            && r == 8'h00) || op == OP_JUMP_ABSOLUTE;
    if (op == OP_JUMP_ABSOLUTE) m_pc = {m_st[6:5], k};
    if (op inside {[OP_COMPLEMENT_FILE:OP_INCREMENT_SKIP_IF_NULL]}) begin
      if (d) m_file[a] = r;
      else m_acc = r;
    end
    if (op == OP_OR_LITERAL_INTO_ACC) m_acc = r;
    if (op inside {[OP_COMPLEMENT_FILE:OP_INCREMENT_FILE],
                   OP_OR_LITERAL_INTO_ACC}) m_st[ZERO_BIT] = (r == 8'h00);
    m_rd = m_file[a];
    @(negedge clk_i);
    chk_all();
    if (m_fl) begin
      m_pc = m_pc + 11'h001;
      m_fl = 1'b0;
      if (hold) begin
        @(posedge clk_i);
        instr_valid_i <= 1'b0;
        @(negedge clk_i);
        chk_all();
      end
    end
  endtask

  task automatic st_wr(logic [7:0] v);
    @(posedge clk_i);
    status_wr_i <= 1'b1;
    status_wdata_i <= v;
    @(posedge clk_i);
    status_wr_i <= 1'b0;
    m_st = v;
    @(negedge clk_i);
    chk("status", {3'h0, m_st}, {3'h0, status_o});
  endtask

  task automatic t_complement();
    exec(OP_COMPLEMENT_FILE, 5'h1f, DEST_FILE, 9'h000, 1'b0);
    exec(OP_COMPLEMENT_FILE, 5'h1f, DEST_ACC, 9'h000, 1'b0);
  endtask

  task automatic t_incdec();
    exec(OP_INCREMENT_FILE, 5'h00, DEST_FILE, 9'h000, 1'b0);
    exec(OP_DECREMENT_FILE, 5'h00, DEST_ACC, 9'h000, 1'b0);
    exec(OP_DECREMENT_FILE, 5'h00, DEST_FILE, 9'h000, 1'b0);
    exec(OP_DECREMENT_FILE, 5'h00, DEST_FILE, 9'h000, 1'b0);
  endtask

  task automatic t_skip();
    exec(OP_INCREMENT_SKIP_IF_NULL, 5'h1f, DEST_FILE, 9'h000, 1'b1);
    exec(OP_DECREMENT_SKIP_IF_NULL, 5'h1f, DEST_ACC, 9'h000, 1'b0);
    exec(OP_INCREMENT_FILE, 5'h02, DEST_FILE, 9'h000, 1'b0);
    exec(OP_DECREMENT_SKIP_IF_NULL, 5'h02, DEST_FILE, 9'h000, 1'b1);
  endtask

  task automatic t_jump();
    st_wr(8'h78);
    exec(OP_JUMP_ABSOLUTE, 5'h00, DEST_ACC, 9'h1ab, 1'b1);
    st_wr(8'h1c);
    exec(OP_JUMP_ABSOLUTE, 5'h00, DEST_ACC, 9'h1ff, 1'b0);
  endtask

  task automatic t_or();
    exec(OP_COMPLEMENT_FILE, 5'h00, DEST_ACC, 9'h000, 1'b0);
    st_wr(8'h18);
    exec(OP_OR_LITERAL_INTO_ACC, 5'h03, DEST_ACC, 9'h100, 1'b0);
    exec(OP_OR_LITERAL_INTO_ACC, 5'h03, DEST_ACC, 9'h05a, 1'b0);
    exec(OP_NO_OPERATION, 5'h03, DEST_FILE, 9'h0ff, 1'b0);
  endtask

  task automatic end_of_test();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(negedge clk_i);
    chk_all();
    t_complement();
    t_incdec();
    t_skip();
    t_jump();
    t_or();
    end_of_test();
  end

  // Whole sequence needs well under 200 cycles
  initial begin
    repeat (2000) @(posedge clk_i);
    error_cnt++;
    end_of_test();
  end
endmodule // file_register_alu_and_branch_tb
